// ---- shared/cpc_pkg.sv ----
// Package with the register map, field layout and reset values of the pad configuration bank.
package cpc_pkg;

    // Number of pads covered by the bank.
    localparam int NUM_PADS = 4;

    // Register indices; the byte address of each register is four times its index.
    localparam logic [15:0] IDX_AUDIO_TX_OUT_PAD_CFG     = 16'hF798;
    localparam logic [15:0] IDX_CTRL_CLOCK_PAD_CFG       = 16'hF799;
    localparam logic [15:0] IDX_CTRL_DATA_PAD_CFG        = 16'hF79A;
    localparam logic [15:0] IDX_CTRL_SELECT_ADDR_PAD_CFG = 16'hF79B;

    // Index table in pad order: entry 0 is the audio transmitter output.
    localparam logic [NUM_PADS-1:0][15:0] PAD_IDX = {
        IDX_CTRL_SELECT_ADDR_PAD_CFG,
        IDX_CTRL_DATA_PAD_CFG,
        IDX_CTRL_CLOCK_PAD_CFG,
        IDX_AUDIO_TX_OUT_PAD_CFG
    };

    // Reset values of the four registers.
    localparam logic [15:0] RST_AUDIO_TX_OUT_PAD_CFG     = 16'h0008;
    localparam logic [15:0] RST_CTRL_CLOCK_PAD_CFG       = 16'h0008;
    localparam logic [15:0] RST_CTRL_DATA_PAD_CFG        = 16'h0008;
    localparam logic [15:0] RST_CTRL_SELECT_ADDR_PAD_CFG = 16'h0018;

    // Reset table in pad order.
    localparam logic [NUM_PADS-1:0][15:0] PAD_RST = {
        RST_CTRL_SELECT_ADDR_PAD_CFG,
        RST_CTRL_DATA_PAD_CFG,
        RST_CTRL_CLOCK_PAD_CFG,
        RST_AUDIO_TX_OUT_PAD_CFG
    };

    // Field layout shared by every pad register.
    localparam int REG_WIDTH  = 16;
    localparam int PULL_BIT   = 4;
    localparam int SLEW_LSB   = 2;
    localparam int SLEW_MSB   = 3;
    localparam int DRIVE_LSB  = 0;
    localparam int DRIVE_MSB  = 1;
    localparam int RSVD_LSB   = 5;
    localparam int RSVD_MSB   = 15;

    // Slew rate encodings.
    typedef enum logic [1:0] {
        CPC_SLEW_SLOWEST = 2'h0,
        CPC_SLEW_SLOW    = 2'h1,
        CPC_SLEW_FAST    = 2'h2,
        CPC_SLEW_FASTEST = 2'h3
    } cpc_slew_t;

    // Drive strength encodings.
    typedef enum logic [1:0] {
        CPC_DRIVE_LOWEST  = 2'h0,
        CPC_DRIVE_LOW     = 2'h1,
        CPC_DRIVE_HIGH    = 2'h2,
        CPC_DRIVE_HIGHEST = 2'h3
    } cpc_drive_t;

    // Field reset values.
    localparam logic [1:0] RST_SLEW  = 2'h2;
    localparam logic [1:0] RST_DRIVE = 2'h0;

endpackage

// ---- verilog/cpc_pad_reg.sv ----
// One sixteen-bit pad configuration register with byte-lane writes.
`timescale 1ns/1ps

module cpc_pad_reg #(
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Write port.
    input  wire logic        wr_en_i,
    input  wire logic [1:0]  wstrb_i,
    input  wire logic [15:0] wdata_i,
    // Stored value.
    output logic      [15:0] cfg_o
);

    // Next value with byte-lane merge.
    logic [15:0] cfg_d;

    // Lanes whose strobe is low keep their old contents.
    assign cfg_d = {wstrb_i[1] ? wdata_i[15:8] : cfg_o[15:8],
                    wstrb_i[0] ? wdata_i[7:0]  : cfg_o[7:0]};

    // The register itself; reserved bits are stored like the rest because they are read-write.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_o <= RESET_VAL;
        end
        else if (wr_en_i)
        begin
            cfg_o <= cfg_d;
        end
    end

endmodule

// ---- verilog/cpc_pad_cfg.sv ----
// APB slave holding the pad configuration registers and driving the static pad controls.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// What this block does
// RULE1 - Transmitter output pad register at index F798, reset value 0008.
// RULE2 - Its bit 4 enables the output pull-down; resets to zero.
// RULE3 - Control clock pad register at index F799, reset value 0008.
// RULE4 - Its bit 4 enables the clock pin pull-up; resets to zero.
// RULE5 - Control data pad register at index F79A, reset value 0008.
// RULE6 - Its bit 4 enables the data pin pull-up; resets to zero.
// RULE7 - Select or address pad register at index F79B, reset value 0018.
// RULE8 - Its bit 4 enables the select pin pull-up; resets to one.
// RULE9 - Bits 3 to 2 select slew rate, slowest to fastest; reset to 2.
// RULE10 - Bits 1 to 0 select drive strength, lowest to highest; reset to 0.
// RULE11 - Bits 15 to 5 are reserved read-write bits resetting to zero.
// RULE12 - Fields drive pad controls statically, updated the cycle after a write.

module cpc_pad_cfg (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // APB slave port.
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [17:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Pad controls, pad 0 transmitter out, 1 control clock, 2 control data, 3 select or address.
    output logic      [3:0]  pad_pull_en_o,
    output logic      [7:0]  pad_slew_o,
    output logic      [7:0]  pad_drive_o
);

    // Bus state registers.
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pslverr_q;
    logic        pslverr_d;

    // Decode wires.
    logic                          setup_phase;
    logic                          access_done;
    logic                          wr_fire;
    logic                          aligned;
    logic [15:0]                   word_idx;
    logic [cpc_pkg::NUM_PADS-1:0]  hit;
    logic                          any_hit;

    // Stored register contents, one word per pad.
    logic [cpc_pkg::NUM_PADS-1:0][15:0] cfg;

    // The setup cycle arms the answer; the access cycle with pready high completes the transfer.
    assign setup_phase = psel_i && !penable_i && !pready_q;
    assign access_done = psel_i && penable_i && pready_q;
    assign word_idx    = paddr_i[17:2];
    assign aligned     = (paddr_i[1:0] == 2'b00);
    assign any_hit     = |hit;
    // Writes to unmapped or misaligned addresses are dropped and answered with an error.
    assign wr_fire     = access_done && pwrite_i && any_hit;

    // One register per pad with its own decode and write enable.
    genvar k;
    generate
        for (k = 0; k < cpc_pkg::NUM_PADS; k++)
        begin : g_pad
            // Address match for this pad's register.
            assign hit[k] = aligned && (word_idx == cpc_pkg::PAD_IDX[k]); // RULE1 RULE3 RULE5 RULE7

            // Storage, reset to the pad's own value.
            cpc_pad_reg #(
                .RESET_VAL (cpc_pkg::PAD_RST[k])
            ) u_reg (
                .mclk_i    (mclk_i),
                .rst_i     (rst_i),
                .wr_en_i   (wr_fire && hit[k]),
                .wstrb_i   (pstrb_i[1:0]),
                .wdata_i   (pwdata_i[15:0]),
                .cfg_o     (cfg[k])
            ); // RULE11 RULE12

            // Fields go to the pads straight from the register flops, so they never glitch.
            assign pad_pull_en_o[k]       = cfg[k][cpc_pkg::PULL_BIT]; // RULE2 RULE4 RULE6 RULE8
            assign pad_slew_o[2*k+1:2*k]  = cfg[k][cpc_pkg::SLEW_MSB:cpc_pkg::SLEW_LSB]; // RULE9
            assign pad_drive_o[2*k+1:2*k] = cfg[k][cpc_pkg::DRIVE_MSB:cpc_pkg::DRIVE_LSB]; // RULE10
        end
    endgenerate

    // Read selection; the upper half of the bus word always reads as zero.
    always_comb
    begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (hit[0])
        begin
            prdata_d = {16'h0000, cfg[0]};
        end
        else if (hit[1])
        begin
            prdata_d = {16'h0000, cfg[1]};
        end
        else if (hit[2])
        begin
            prdata_d = {16'h0000, cfg[2]};
        end
        else if (hit[3])
        begin
            prdata_d = {16'h0000, cfg[3]};
        end
        else
        begin
            pslverr_d = 1'b1;
        end
    end

    // Answer registers: one access cycle per transfer, read data captured during setup.
    // Capturing in setup keeps prdata stable through the access phase at the cost of no wait states.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else if (setup_phase)
        begin
            pready_q  <= 1'b1;
            pslverr_q <= pslverr_d;
            prdata_q  <= pwrite_i ? 32'h0000_0000 : prdata_d;
        end
        else if (access_done)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Bus outputs come straight from the answer flops.
    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;

    // Helper: remembers that the previous edge saw reset asserted.
    logic rst_seen_q;
    always_ff @(posedge mclk_i)
    begin
        rst_seen_q <= rst_i;
    end

    // Helper: the transfer that completed at the last edge, for write checks.
    logic        wr_prev_q;
    logic [3:0]  hit_prev_q;
    logic [15:0] wdata_prev_q;
    logic [1:0]  wstrb_prev_q;
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_prev_q    <= 1'b0;
            hit_prev_q   <= 4'h0;
            wdata_prev_q <= 16'h0000;
            wstrb_prev_q <= 2'b00;
        end
        else
        begin
            wr_prev_q    <= wr_fire;
            hit_prev_q   <= hit;
            wdata_prev_q <= pwdata_i[15:0];
            wstrb_prev_q <= pstrb_i[1:0];
        end
    end

    // Reset values seen at the first edge after reset is released.
    tx_reset_val_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE1 RULE2
        rst_seen_q |-> (cfg[0] == cpc_pkg::RST_AUDIO_TX_OUT_PAD_CFG && pad_pull_en_o[0] == 1'b0))
        else $error("transmitter pad register reset value wrong");

    clk_reset_val_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE3 RULE4
        rst_seen_q |-> (cfg[1] == cpc_pkg::RST_CTRL_CLOCK_PAD_CFG && pad_pull_en_o[1] == 1'b0))
        else $error("control clock pad register reset value wrong");

    data_reset_val_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE5 RULE6
        rst_seen_q |-> (cfg[2] == cpc_pkg::RST_CTRL_DATA_PAD_CFG && pad_pull_en_o[2] == 1'b0))
        else $error("control data pad register reset value wrong");

    sel_reset_val_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE7 RULE8
        rst_seen_q |-> (cfg[3] == cpc_pkg::RST_CTRL_SELECT_ADDR_PAD_CFG && pad_pull_en_o[3] == 1'b1))
        else $error("select pad register reset value wrong");

    // Pull enables follow bit 4 of the last write that set the low byte.
    tx_pull_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE2
        (wr_fire && hit[0] && pstrb_i[0]) |=> (pad_pull_en_o[0] == $past(pwdata_i[cpc_pkg::PULL_BIT])))
        else $error("transmitter pull enable did not follow write");

    clk_pull_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE4
        (wr_fire && hit[1] && pstrb_i[0]) |=> (pad_pull_en_o[1] == $past(pwdata_i[cpc_pkg::PULL_BIT])))
        else $error("clock pin pull enable did not follow write");

    data_pull_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE6
        (wr_fire && hit[2] && pstrb_i[0]) |=> (pad_pull_en_o[2] == $past(pwdata_i[cpc_pkg::PULL_BIT])))
        else $error("data pin pull enable did not follow write");

    sel_pull_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE8
        (wr_fire && hit[3] && pstrb_i[0]) |=> (pad_pull_en_o[3] == $past(pwdata_i[cpc_pkg::PULL_BIT])))
        else $error("select pin pull enable did not follow write");

    // Slew and drive fields reset to fast and lowest on every pad.
    slew_reset_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE9
        rst_seen_q |-> (pad_slew_o == {4{cpc_pkg::RST_SLEW}}))
        else $error("slew fields not fast after reset");

    drive_reset_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE10
        rst_seen_q |-> (pad_drive_o == {4{cpc_pkg::RST_DRIVE}}))
        else $error("drive fields not lowest after reset");

    // Reserved bits start at zero and read back what was written.
    rsvd_reset_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        rst_seen_q |-> (cfg[0][15:5] == 11'h000 && cfg[1][15:5] == 11'h000 &&
                        cfg[2][15:5] == 11'h000 && cfg[3][15:5] == 11'h000))
        else $error("reserved bits not zero after reset");

    tx_rsvd_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        (wr_prev_q && hit_prev_q[0] && wstrb_prev_q[1]) |-> (cfg[0][15:8] == wdata_prev_q[15:8]))
        else $error("transmitter pad upper byte did not take the write");

    clk_rsvd_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        (wr_prev_q && hit_prev_q[1] && wstrb_prev_q[1]) |-> (cfg[1][15:8] == wdata_prev_q[15:8]))
        else $error("clock pad upper byte did not take the write");

    data_rsvd_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        (wr_prev_q && hit_prev_q[2] && wstrb_prev_q[1]) |-> (cfg[2][15:8] == wdata_prev_q[15:8]))
        else $error("data pad upper byte did not take the write");

    sel_rsvd_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        (wr_prev_q && hit_prev_q[3] && wstrb_prev_q[1]) |-> (cfg[3][15:8] == wdata_prev_q[15:8]))
        else $error("select pad upper byte did not take the write");

    // A completed write shows on the pad controls in the next cycle and stays until rewritten.
    pad_update_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE12
        (wr_prev_q && hit_prev_q[1] && wstrb_prev_q[0]) |->
        (pad_slew_o[3:2] == wdata_prev_q[3:2] && pad_drive_o[3:2] == wdata_prev_q[1:0]))
        else $error("pad controls did not take the written value");

    tx_pad_update_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE9 RULE10 RULE12
        (wr_prev_q && hit_prev_q[0] && wstrb_prev_q[0]) |->
        (pad_slew_o[1:0] == wdata_prev_q[3:2] && pad_drive_o[1:0] == wdata_prev_q[1:0]))
        else $error("transmitter pad controls did not take the written value");

    data_pad_update_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE9 RULE10 RULE12
        (wr_prev_q && hit_prev_q[2] && wstrb_prev_q[0]) |->
        (pad_slew_o[5:4] == wdata_prev_q[3:2] && pad_drive_o[5:4] == wdata_prev_q[1:0]))
        else $error("data pad controls did not take the written value");

    sel_pad_update_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE9 RULE10 RULE12
        (wr_prev_q && hit_prev_q[3] && wstrb_prev_q[0]) |->
        (pad_slew_o[7:6] == wdata_prev_q[3:2] && pad_drive_o[7:6] == wdata_prev_q[1:0]))
        else $error("select pad controls did not take the written value");

    // Pads and registers move only on a completed write, never on a read or a setup cycle.
    pad_static_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE12
        !wr_fire |=> ($stable(pad_slew_o) && $stable(pad_drive_o) && $stable(pad_pull_en_o)))
        else $error("pad controls changed without a write");

    read_no_side_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11 RULE12
        (access_done && !pwrite_i) |=> $stable(cfg))
        else $error("a read changed a pad register");

    setup_no_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE12
        (psel_i && !penable_i) |=> $stable(cfg))
        else $error("a setup cycle changed a pad register");

    // A byte lane whose strobe is low keeps its contents across the write.
    low_lane_hold_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE12
        (wr_fire && hit[1] && !pstrb_i[0]) |=> (cfg[1][7:0] == $past(cfg[1][7:0])))
        else $error("low byte changed without its strobe");

    high_lane_hold_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        (wr_fire && hit[1] && !pstrb_i[1]) |=> (cfg[1][15:8] == $past(cfg[1][15:8])))
        else $error("high byte changed without its strobe");

    // The answer comes in the cycle after setup and holds read data through it.
    apb_answer_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        (psel_i && !penable_i && !pready_o) |=> (pready_o ##1 !pready_o))
        else $error("APB answer not one cycle after setup");

    ok_answer_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        (setup_phase && any_hit) |=> (pready_o && !pslverr_o))
        else $error("mapped access answered with an error");

    err_answer_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        (setup_phase && !any_hit) |=> (pready_o && pslverr_o && prdata_o == 32'h0000_0000))
        else $error("unmapped access not answered with an error");

    misaligned_err_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        (setup_phase && paddr_i[1:0] != 2'b00) |=> pslverr_o)
        else $error("misaligned access not answered with an error");

    write_rdata_zero_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        (setup_phase && pwrite_i) |=> (prdata_o == 32'h0000_0000))
        else $error("read data not zero during a write");

    upper_half_zero_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE11
        pready_o |-> (prdata_o[31:16] == 16'h0000))
        else $error("upper half of read data not zero");

    err_with_ready_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        pslverr_o |-> pready_o)
        else $error("error flag shown outside the access cycle");

    ready_drop_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        access_done |=> !pready_o)
        else $error("pready stayed high after the access cycle");

    idle_ready_low_a : assert property (@(posedge mclk_i) disable iff (rst_i)
        !psel_i |=> !pready_o)
        else $error("pready raised while the bus is idle");

    // A refused write leaves every register as it was.
    refused_write_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE1 RULE3 RULE5 RULE7
        (access_done && pwrite_i && !any_hit) |=> $stable(cfg))
        else $error("a refused write changed a pad register");

    // Read data carry the register word in the low half during the access cycle.
    tx_read_data_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE1
        (setup_phase && !pwrite_i && hit[0]) |=>
        (prdata_o == {16'h0000, $past(cfg[0])}))
        else $error("transmitter pad register read data wrong");

    clk_read_data_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE3
        (setup_phase && !pwrite_i && hit[1]) |=>
        (prdata_o == {16'h0000, $past(cfg[1])}))
        else $error("clock pad register read data wrong");

    data_read_data_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE5
        (setup_phase && !pwrite_i && hit[2]) |=>
        (prdata_o == {16'h0000, $past(cfg[2])}))
        else $error("data pad register read data wrong");

    sel_read_data_a : assert property (@(posedge mclk_i) disable iff (rst_i) // RULE7
        (setup_phase && !pwrite_i && hit[3]) |=>
        (prdata_o == {16'h0000, $past(cfg[3])}))
        else $error("select pad register read data wrong");

endmodule

// ---- bench/cpc_pad_cfg_bench.sv ----
// Self-checking testbench for the pad configuration register bank on its APB port.
`timescale 1ns/1ps

module cpc_pad_cfg_bench;

    // Stimulus, observed outputs and bench bookkeeping.
    logic        mclk_i    = 1'b0;
    logic        rst_i     = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [17:0] paddr_i   = 18'h0_0000;
    logic [31:0] pwdata_i  = 32'h0000_0000;
    logic [3:0]  pstrb_i   = 4'h0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [3:0]  pad_pull_en_o;
    logic [7:0]  pad_slew_o;
    logic [7:0]  pad_drive_o;
    logic [15:0] model_reg [4];
    logic [31:0] rd;
    logic        er;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cycles    = 0;

    cpc_pad_cfg dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .pad_pull_en_o(pad_pull_en_o), .pad_slew_o(pad_slew_o), .pad_drive_o(pad_drive_o)
    );

    // Clock at 250 MHz and a cycle ceiling well above the fewer than a hundred cycles the tests need.
    always #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        n_tests++;
        if (got !== want)
        begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    function automatic logic [17:0] addr_of(input int k);
        return {cpc_pkg::PAD_IDX[k], 2'b00};
    endfunction

    // One APB transfer, entered right after a rising edge; psel stays high so a transfer may follow at once.
    // The master waits for pready however long it takes; only the cycle ceiling above ends a hang.
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd, input logic [3:0] st);
        int n;
        n = 0;
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= wd;
        pstrb_i  <= st;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (pready_o !== 1'b1);
        chk(32'(n), 32'h0000_0001, "answer latency");
        rd = prdata_o;
        er = pslverr_o;
        penable_i <= 1'b0;
    endtask

    task automatic idle();
        psel_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Pad outputs are compared against the bench's own copy of every register.
    task automatic check_pads();
        logic [3:0] pl;
        logic [7:0] sl;
        logic [7:0] dr;
        for (int k = 0; k < 4; k++)
        begin
            pl[k]        = model_reg[k][4];
            sl[2*k +: 2] = model_reg[k][3:2];
            dr[2*k +: 2] = model_reg[k][1:0];
        end
        chk(32'(pad_pull_en_o), 32'(pl), "pull enables");
        chk(32'(pad_slew_o), 32'(sl), "slew");
        chk(32'(pad_drive_o), 32'(dr), "drive");
    endtask

    // Back-to-back reads of all four registers, then the bus goes idle.
    task automatic read_all();
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b0, addr_of(k), 32'h0000_0000, 4'h0);
            chk(rd, {16'h0000, model_reg[k]}, "readback");
            chk(32'(er), 32'h0000_0000, "read error");
        end
        idle();
    endtask

    // Reset values, checked on the pads and by reading every register.
    task automatic test_reset();
        model_reg = '{16'h0008, 16'h0008, 16'h0008, 16'h0018};
        check_pads();
        read_all();
        $display("reset values done");
    endtask

    // Every slew and drive code, pull written 1, 0, 1, 0 in pad order, reserved bits set; pads keep old values until the write completes.
    task automatic test_write();
        logic [15:0] v;
        for (int k = 0; k < 4; k++)
        begin
            v = {11'h5A5 ^ 11'(k), ~k[0], 2'(k), 2'(3 - k)};
            apb(1'b1, addr_of(k), {16'hFFFF, v}, 4'hF);
            chk(32'(er), 32'h0000_0000, "write error");
            check_pads();
            model_reg[k] = v;
            idle();
            check_pads();
        end
        read_all();
        $display("write and readback done");
    endtask

    // Byte lanes are written independently, back to back.
    task automatic test_strobes();
        apb(1'b1, addr_of(1), 32'hFFFF_FFFF, 4'h1);
        apb(1'b1, addr_of(1), 32'h0000_0000, 4'h2);
        idle();
        model_reg[1] = 16'h00FF;
        check_pads();
        read_all();
        $display("byte lanes done");
    endtask

    // Unmapped and misaligned addresses answer with an error and leave every register alone.
    task automatic test_refused();
        apb(1'b1, {16'hF79C, 2'b00}, 32'h0000_FFFF, 4'hF);
        chk(32'(er), 32'h0000_0001, "unmapped write");
        apb(1'b1, addr_of(3) | 18'h0_0002, 32'h0000_0000, 4'hF);
        chk(32'(er), 32'h0000_0001, "misaligned write");
        apb(1'b0, {16'hF797, 2'b00}, 32'h0000_0000, 4'h0);
        chk(32'(er), 32'h0000_0001, "unmapped read");
        chk(rd, 32'h0000_0000, "unmapped data");
        idle();
        check_pads();
        read_all();
        $display("refused accesses done");
    endtask

    // Main sequence: power-up reset, traffic, then a reset in mid-run.
    initial
    begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        test_reset();
        test_write();
        test_strobes();
        test_refused();
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        test_reset();
        final_report();
    end

endmodule
